//--- rtl/tof_pkg.sv
// Purpose: Shared constants and types for the ultrasonic time-of-flight ranger
// Assumes: 50 MHz reference clock
// Notes: Cycle counts are derived from printed times and rates
package tof_pkg;

  // Clock rate
  localparam real CLK_HZ = 50.0e6;

  // Periodic start interval in continuous mode
  localparam real START_PERIOD_MS = 204.8;
  localparam int unsigned START_PERIOD_CYC = int'(START_PERIOD_MS * 1.0e-3 * CLK_HZ);

  // Transmit tone and its half period
  localparam real TONE_HZ = 40.0e3;
  localparam int unsigned TONE_HALF_CYC = int'(CLK_HZ / (2.0 * TONE_HZ));

  // Sound speed in inches per second; one inch of range is two inches of flight
  localparam real SOUND_IN_PER_S = 13627.2;
  localparam int unsigned INCH_RT_CYC = int'(2.0 * CLK_HZ / SOUND_IN_PER_S);

  // Default burst length in tone cycles
  localparam int unsigned BURST_CYCLES_DEF = 8;

  // Range limits in inches
  localparam int unsigned DIST_W = 7;
  localparam logic [6:0] MIN_INCHES = 7'h06;
  localparam logic [6:0] MAX_INCHES = 7'h63;
  localparam logic [6:0] ZERO_INCHES = 7'h00;

  // Synchroniser lane positions
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned LANE_ECHO = 0;
  localparam int unsigned LANE_BUTTON = 1;
  localparam int unsigned LANE_MODE = 2;

  // Measurement result carrier
  typedef struct packed {
    logic valid;
    logic out_of_range;
    logic [6:0] inches;
  } result_t;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BURST = 3'b010,
    ST_LISTEN = 3'b100
  } meas_state_t;

endpackage : tof_pkg

//--- rtl/tick_gen.sv
// Purpose: Counter that emits a one-cycle enable pulse every PERIOD cycles
// Assumes: Single clock, synchronous active-high reset
// Notes: Clear restarts the count so the first pulse lands PERIOD cycles later
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned PERIOD = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic enable,
  output logic tick
);

  localparam int unsigned CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_ff;
  logic tick_ff;

  // Period counter and pulse
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || clear || !enable)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (cnt_ff == LAST)
    begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + ONE;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule : tick_gen

//--- rtl/sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels relative to the clock
// Notes: Only the second stage may be read by logic
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] stable_ff;

  // Two stages, first feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= '0;
      stable_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      stable_ff <= meta_ff;
    end
  end

  assign sync_out = stable_ff;

endmodule : sync2

//--- rtl/ultrasonic_tof_ranger.sv
// Purpose: Ultrasonic time-of-flight ranger: burst, listen, time echo, report inches
// Assumes: 50 MHz ref_clk, synchronous active-high sys_rst, async pins synchronised
// Notes: Distance counts whole inches of range while the echo is awaited
// Behaviour
// RULE_01 - Continuous mode starts a measurement every 204.8 ms unprompted.
// RULE_02 - Manual mode starts one measurement per button press, never periodically.
// RULE_03 - Busy indicator is on exactly while a measurement runs.
// RULE_04 - Each measurement begins with a 40 kHz square burst on transmit drive.
// RULE_05 - After the burst the transmit drive stays idle until measurement ends.
// RULE_06 - Comparator assertion while listening marks echo arrival.
// RULE_07 - Round-trip time is counted from burst start to echo.
// RULE_08 - Distance in inches is 13627.2 times round-trip seconds, halved.
// RULE_09 - Distance is reported as whole inches, one inch resolution.
// RULE_10 - Echoes before 6 inches of range are ignored; no smaller result.
// RULE_11 - Results above 99 inches are out of range.
// RULE_12 - No echo within the window gives an out-of-range flag.
// RULE_13 - Burst length in tone cycles is a parameter, fixed per measurement.
// RULE_14 - Listening times out at the 99 inch round trip, out of range.
`timescale 1ns/1ps
module ultrasonic_tof_ranger
  import tof_pkg::*;
#(
  parameter int unsigned BURST_CYCLES = BURST_CYCLES_DEF,
  parameter int unsigned START_CYC = START_PERIOD_CYC,
  parameter int unsigned INCH_CYC = INCH_RT_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic continuous_mode,
  input wire logic start_button,
  input wire logic echo_cmp,
  output logic tx_drive,
  output logic busy_led,
  output result_t result
);

  localparam int unsigned HALF_W = $clog2(2 * BURST_CYCLES + 1);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(2 * BURST_CYCLES - 1);
  localparam logic [HALF_W-1:0] HALF_ONE = HALF_W'(1);
  localparam logic [6:0] INCH_ONE = 7'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  logic [SYNC_W-1:0] pins_sync;
  logic echo_s;
  logic button_s;
  logic mode_s;
  logic button_prev_ff;
  logic button_rise;

  sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({continuous_mode, start_button, echo_cmp}),
    .sync_out(pins_sync)
  );

  // Lane split of synchronised pins
  assign echo_s = pins_sync[LANE_ECHO];
  assign button_s = pins_sync[LANE_BUTTON];
  assign mode_s = pins_sync[LANE_MODE];

  // Button press edge
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      button_prev_ff <= 1'b0;
    else
      button_prev_ff <= button_s;
  end

  assign button_rise = button_s && !button_prev_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Rate dividers

  meas_state_t state_ff;
  meas_state_t nxt_state;
  logic start_req;
  logic period_tick;
  logic half_tick;
  logic inch_tick;
  logic launch;

  // Periodic trigger runs only in continuous mode
  tick_gen #(
    .PERIOD(START_CYC)
  ) u_period (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(1'b0),
    .enable(mode_s),
    .tick(period_tick)
  );

  // Tone half-period, restarted at each launch
  tick_gen #(
    .PERIOD(TONE_HALF_CYC)
  ) u_tone (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(launch),
    .enable(state_ff == ST_BURST),
    .tick(half_tick)
  );

  // One inch of range per tick, restarted at each launch
  tick_gen #(
    .PERIOD(INCH_CYC)
  ) u_inch (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(launch),
    .enable(state_ff != ST_IDLE),
    .tick(inch_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer

  logic [HALF_W-1:0] half_cnt_ff;
  logic [6:0] inch_cnt_ff;
  logic echo_hit;
  logic timeout;
  logic burst_done;

  // Trigger source follows the mode
  assign start_req = mode_s ? period_tick : button_rise; // RULE_01 RULE_02
  assign launch = (state_ff == ST_IDLE) && start_req;
  assign burst_done = (state_ff == ST_BURST) && half_tick && (half_cnt_ff == HALF_LAST);
  // Echo only counts once past the blind zone
  assign echo_hit = (state_ff == ST_LISTEN) && echo_s && (inch_cnt_ff >= MIN_INCHES); // RULE_06 RULE_10
  assign timeout = (state_ff == ST_LISTEN) && inch_tick && (inch_cnt_ff == MAX_INCHES); // RULE_14

  // Next state
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:
        if (launch)
          nxt_state = ST_BURST;
      ST_BURST:
        if (burst_done)
          nxt_state = ST_LISTEN;
      ST_LISTEN:
        if (echo_hit || timeout)
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Half-period count within the burst
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || launch)
      half_cnt_ff <= '0;
    else if ((state_ff == ST_BURST) && half_tick)
      half_cnt_ff <= half_cnt_ff + HALF_ONE; // RULE_13
  end

  // Round-trip time in inches of range since burst start
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || launch)
      inch_cnt_ff <= ZERO_INCHES; // RULE_07
    else if (inch_tick && (inch_cnt_ff != MAX_INCHES))
      inch_cnt_ff <= inch_cnt_ff + INCH_ONE; // RULE_08 RULE_09
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic tx_ff;
  logic busy_ff;
  result_t result_ff;

  // Transmit drive toggles in burst, idle otherwise
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || (state_ff != ST_BURST))
      tx_ff <= 1'b0; // RULE_05
    else if (half_tick)
      tx_ff <= !tx_ff; // RULE_04
  end

  // Busy indicator
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      busy_ff <= 1'b0;
    else
      busy_ff <= (nxt_state != ST_IDLE); // RULE_03
  end

  // Result capture, valid pulses for one cycle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      result_ff <= '0;
    else if (echo_hit)
    begin
      result_ff.valid <= 1'b1;
      result_ff.out_of_range <= 1'b0;
      result_ff.inches <= inch_cnt_ff; // RULE_07 RULE_09
    end
    else if (timeout)
    begin
      result_ff.valid <= 1'b1;
      result_ff.out_of_range <= 1'b1; // RULE_11 RULE_12
      result_ff.inches <= ZERO_INCHES;
    end
    else
      result_ff.valid <= 1'b0;
  end

  assign tx_drive = tx_ff;
  assign busy_led = busy_ff;
  assign result = result_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_echo_hit;
    (state_ff == ST_LISTEN) && echo_s && (inch_cnt_ff >= MIN_INCHES);
  endsequence

  sequence seq_good_result;
    result_ff.valid && !result_ff.out_of_range && (state_ff == ST_IDLE);
  endsequence

  sequence seq_launch;
    (state_ff == ST_IDLE) && start_req;
  endsequence

  a_busy_tracks_state: assert property ( // RULE_03
    busy_ff == (state_ff != ST_IDLE))
    else $error("busy indicator disagrees with state");

  a_periodic_start: assert property ( // RULE_01
    mode_s && period_tick && (state_ff == ST_IDLE) |=> (state_ff == ST_BURST) && busy_ff)
    else $error("periodic tick did not start a measurement");

  a_manual_no_auto: assert property ( // RULE_02
    !mode_s && !button_rise && (state_ff == ST_IDLE) |=> (state_ff == ST_IDLE))
    else $error("manual mode started without a press");

  a_burst_toggle: assert property ( // RULE_04
    (state_ff == ST_BURST) && half_tick && !burst_done |=> tx_ff != $past(tx_ff))
    else $error("transmit drive did not toggle on half period");

  a_tx_quiet: assert property ( // RULE_05
    (state_ff != ST_BURST) |=> !tx_ff)
    else $error("transmit drive active outside burst");

  a_burst_end: assert property ( // RULE_05
    burst_done |=> (state_ff == ST_LISTEN) && !tx_ff)
    else $error("burst did not end with drive idle");

  a_burst_length: assert property ( // RULE_13
    seq_launch |=> (half_cnt_ff == '0) ##1 ((state_ff == ST_BURST) && !half_tick)[*3])
    else $error("burst did not start from zero");

  a_echo_taken: assert property ( // RULE_06
    seq_echo_hit |=> seq_good_result ##0 (result_ff.inches == $past(inch_cnt_ff)))
    else $error("echo not reported with its round trip count");

  a_blind_zone: assert property ( // RULE_10
    (state_ff != ST_IDLE) && (inch_cnt_ff < MIN_INCHES) |=> !result_ff.valid)
    else $error("echo accepted inside blind zone");

  a_max_range: assert property ( // RULE_11
    result_ff.valid && !result_ff.out_of_range |-> (result_ff.inches <= MAX_INCHES)
      && (result_ff.inches >= MIN_INCHES))
    else $error("reported distance outside limits");

  a_timeout_oor: assert property ( // RULE_12
    timeout && !echo_s |=> result_ff.valid && result_ff.out_of_range && !busy_ff)
    else $error("timeout did not flag out of range");

  a_valid_pulse: assert property ( // result valid is a one-cycle pulse
    result_ff.valid |=> !result_ff.valid)
    else $error("result valid held longer than one cycle");

  a_listen_ends: assert property ( // RULE_14
    (state_ff == ST_LISTEN) && !timeout && !echo_hit |=> (state_ff == ST_LISTEN) && busy_ff)
    else $error("listening ended without echo or timeout");

endmodule : ultrasonic_tof_ranger

//--- sim/echo_front.sv
// Purpose: Receiver front end model, comparator pulse after a set flight delay
// Assumes: Delay counts cycles from the first transmit rise of a burst
// Notes: Negative delay models a target that returns no echo
`timescale 1ns/1ps
module echo_front
  import tof_pkg::*;
(
  input wire logic ref_clk,
  input wire logic tx_drive,
  input wire integer echo_dly,
  output logic echo_cmp
);
  localparam int GAP = 2 * TONE_HALF_CYC;
  int cnt = -1;
  int idle = 2 * TONE_HALF_CYC + 1;
  logic tx_q = 1'b0;

  initial echo_cmp = 1'b0;

  // Flight timer restarts at a transmit rise after a quiet gap longer than a tone period,
  // so back-to-back measurements each time their own burst
  always @(negedge ref_clk)
  begin
    if (tx_drive && !tx_q && idle > GAP)
      cnt = 0;
    else if (cnt >= 0)
      cnt = cnt + 1;
    idle = tx_drive ? 0 : idle + 1;
    tx_q = tx_drive;
    echo_cmp <= (echo_dly >= 0) && (cnt >= echo_dly) && (cnt < echo_dly + 200);
  end
endmodule : echo_front

//--- sim/tb.sv
// Purpose: Self-checking bench for the ultrasonic ranger
// Assumes: Shortened counts: 2 tone cycles, 100 cycles per inch, 12000 cycle period
// Notes: Echo delays sit mid-inch so sync latency cannot shift the result
`timescale 1ns/1ps
module tb;
  import tof_pkg::*;
  localparam int BC = 2;
  localparam int IC = 100;
  localparam int SC = 12000;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic continuous_mode = 1'b0;
  logic start_button = 1'b0;
  logic echo_cmp;
  logic tx_drive;
  logic busy_led;
  result_t result;
  result_t got;
  int dly = -1;
  int mismatches = 0;
  int checks_done = 0;
  int cyc, rises, first, lastf, vcyc, nval, gcyc, vg;
  logic vbusy, busy_q, tx_q;

  ultrasonic_tof_ranger #(.BURST_CYCLES(BC), .START_CYC(SC), .INCH_CYC(IC)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .continuous_mode(continuous_mode),
    .start_button(start_button), .echo_cmp(echo_cmp), .tx_drive(tx_drive),
    .busy_led(busy_led), .result(result));

  echo_front front (.ref_clk(ref_clk), .tx_drive(tx_drive), .echo_dly(dly),
    .echo_cmp(echo_cmp));

  always #10 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: cycles since busy rise, tone edges, result capture
  initial
  begin
    {nval, gcyc, cyc, rises} = '0;
    {busy_q, tx_q} = 2'b00;
  end
  always @(negedge ref_clk)
  begin
    gcyc++;
    if (busy_led === 1'b1 && busy_q !== 1'b1)
    begin
      cyc = 0;
      rises = 0;
      first = -1;
      lastf = -1;
    end
    else
      cyc++;
    if (tx_drive === 1'b1 && tx_q !== 1'b1)
    begin
      rises++;
      if (first < 0)
        first = cyc;
    end
    if (tx_drive === 1'b0 && tx_q === 1'b1)
      lastf = cyc;
    if (result.valid === 1'b1)
    begin
      got = result;
      vcyc = cyc;
      vbusy = busy_led;
      vg = gcyc;
      nval++;
    end
    busy_q = busy_led;
    tx_q = tx_drive;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare and helper tasks
  task automatic chk_res(input result_t g, input result_t e);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: result %h, wanted %h", $time, g, e);
    end
  endtask : chk_res

  task automatic chk_flag(input logic g, input logic e, input string what);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk_flag

  task automatic press();
    @(negedge ref_clk);
    start_button = 1'b1;
    repeat (4) @(negedge ref_clk);
    start_button = 1'b0;
  endtask : press

  task automatic wait_valid();
    int n0;
    n0 = nval;
    for (int i = 0; i < 30000 && nval == n0; i++)
      @(negedge ref_clk);
    chk_flag(nval != n0, 1'b1, "no result");
  endtask : wait_valid

  task automatic check_meas(input logic oor, input logic [6:0] inch);
    chk_res(got, result_t'{1'b1, oor, inch});
    chk_flag(vbusy, 1'b0, "busy after result");
    chk_flag(rises == BC, 1'b1, "tone cycle count");
    chk_flag(first == TONE_HALF_CYC + 1, 1'b1, "tone start");
    chk_flag(lastf == 2 * BC * TONE_HALF_CYC + 1, 1'b1, "drive not idle");
  endtask : check_meas

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_manual(input int d, input logic oor, input logic [6:0] inch);
    dly = d;
    press();
    wait_valid();
    check_meas(oor, inch);
    $display("manual test, delay %0d, done", d);
  endtask : t_manual

  task automatic t_timeout();
    t_manual(-1, 1'b1, 7'h00);
    chk_flag(vcyc >= 100 * IC - 2 && vcyc <= 100 * IC + 2, 1'b1, "timeout span");
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_ignore();
    int n1;
    dly = 3397;
    press();
    repeat (2000) @(negedge ref_clk);
    press();
    wait_valid();
    n1 = nval;
    check_meas(1'b0, 7'h28);
    repeat (SC + 1000) @(negedge ref_clk);
    chk_flag(nval == n1, 1'b1, "extra measurement");
    $display("ignore test done");
  endtask : t_ignore

  task automatic t_cont();
    int g1;
    dly = 3397;
    continuous_mode = 1'b1;
    wait_valid();
    g1 = vg;
    wait_valid();
    chk_flag(vg - g1 == SC, 1'b1, "start period");
    check_meas(1'b0, 7'h28);
    continuous_mode = 1'b0;
    $display("continuous test done");
  endtask : t_cont

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial
  begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk_res(result, '0);
    chk_flag(tx_drive | busy_led, 1'b0, "outputs after reset");
    $display("reset test done");
    t_manual(3397, 1'b0, 7'h28);
    t_manual(9297, 1'b0, 7'h63);
    t_timeout();
    t_manual(500, 1'b1, 7'h00);
    t_ignore();
    t_cont();
    give_verdict();
  end

  initial
  begin
    #1900000;
    mismatches++;
    give_verdict();
  end
endmodule : tb
